// >>> inc/rimon_consts.svh
`ifndef RIMON_CONSTS_SVH
`define RIMON_CONSTS_SVH

// register offsets
`define RIMON_ADDR_STATUS     8'h21
`define RIMON_ADDR_FMT_PAIR   8'h80
`define RIMON_ADDR_FMT_TB     8'h81
`define RIMON_ADDR_MON_CFG    8'h83

// reset values
`define RIMON_RST_FMT_PAIR    8'h00
`define RIMON_RST_FMT_TB      8'h00
`define RIMON_RST_MON_CFG     8'h00

// input format fields and power-down bits
`define RIMON_FMT0_LSB        0
`define RIMON_FMT1_LSB        4
`define RIMON_FMT2_LSB        0
`define RIMON_PD0_BIT         2
`define RIMON_PD1_BIT         6
`define RIMON_PD2_BIT         2
`define RIMON_USE_REGS_BIT    7

// monitor configuration fields
`define RIMON_MON_EN_BIT      7
`define RIMON_NOM_BIT         5
`define RIMON_TB8K_BIT        4
`define RIMON_TBSEL_LSB       2
`define RIMON_WIN_LSB         0

// status fields
`define RIMON_ST_LOSS_LSB     0
`define RIMON_ST_ACT_BIT      3
`define RIMON_ST_FREQ_LSB     4

// timing: clock period and loss threshold (1 MHz)
`define RIMON_CLK_NS          4
`define RIMON_LOSS_NS         1000
`define RIMON_LOSS_CYC        (`RIMON_LOSS_NS / `RIMON_CLK_NS)
// 8 kHz timebase loss limits in active reference cycles (6.1 kHz, 4.7 kHz)
`define RIMON_LIM_8K_25M      13'h1002
`define RIMON_LIM_8K_19M      13'h1028

// gate lengths in timebase edges, all 40 ms
`define RIMON_GATE_8K         22'h00_0140
`define RIMON_GATE_10M        22'h06_1A80
`define RIMON_GATE_19M        22'h0B_DD80
`define RIMON_GATE_25M        22'h0F_4240
`define RIMON_GATE_38M        22'h17_BB00

// nominal active counts over 40 ms
`define RIMON_NOM_25M         22'h0F_4240
`define RIMON_NOM_19M         22'h0B_DD80

// window half-widths in counts (10, 25, 50, 100 ppm)
`define RIMON_WIN_25M_0       22'h00_000A
`define RIMON_WIN_25M_1       22'h00_0019
`define RIMON_WIN_25M_2       22'h00_0032
`define RIMON_WIN_25M_3       22'h00_0064
`define RIMON_WIN_19M_0       22'h00_0007
`define RIMON_WIN_19M_1       22'h00_0013
`define RIMON_WIN_19M_2       22'h00_0026
`define RIMON_WIN_19M_3       22'h00_004D

`endif

// >>> inc/rimon_pkg.sv
package rimon_pkg;

  typedef enum logic [1:0] {
    FMT_CMOS = 2'h0,
    FMT_DIFF = 2'h1,
    FMT_XTAL = 2'h2
  } rimon_fmt_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_MEAS = 2'h2
  } rimon_state_type;

  typedef enum logic [1:0] {
    FS_VALID = 2'h0,
    FS_SLOW  = 2'h1,
    FS_FAST  = 2'h2,
    FS_FAULT = 2'h3
  } rimon_stat_type;

endpackage : rimon_pkg

// >>> design/rimon_presence.sv
module rimon_presence (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        edge_seen,
  input  wire logic        tick,
  input  wire logic [12:0] limit,
  output logic             lost
);

  logic [12:0] gap_q;

  // absent until the first edge is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_q <= 13'h0000;
      lost  <= 1'b1;
    end else if (edge_seen) begin
      gap_q <= 13'h0000;
      lost  <= 1'b0;
    end else if (tick) begin
      if (gap_q >= limit) begin
        lost <= 1'b1;
      end else begin
        gap_q <= gap_q + 13'h0001;
      end
    end
  end

  loss_rise_a: assert property (@(posedge clk) disable iff (srst)
    $rose(lost) |-> $past(gap_q) >= $past(limit))
    else $error("loss flag raised before the gap limit");

  loss_clear_a: assert property (@(posedge clk) disable iff (srst)
    edge_seen |=> !lost)
    else $error("loss flag not cleared by an edge");

  loss_seen_c: cover property (@(posedge clk) disable iff (srst) $rose(lost));

endmodule : rimon_presence

// >>> design/rimon_top.sv
`include "rimon_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - format codes 00 CMOS, 01 differential, 10 crystal
// - format fields at 0x080 [1:0],[5:4], 0x081 [1:0]
// - mode from sampled strap or the registers
// - CMOS receiver off by power-down or other mode
// - differential receiver off by power-down or other mode
// - crystal off likewise, or for the first two inputs when not selected
// - monitor runs only when 0x083 bit 7 set
// - measure active reference, window from 0x083 [1:0]
// - 0x083 bit 5 picks 25 or 19.44 MHz
// - timebase frequency from 0x083 bit 4, [3:2]
// - only the active reference is frequency checked
// - result at 0x021 [5:4]: valid/slow/fast/fault
// - fault pin is OR of status bits while the monitor runs
// - loss flag when clock absent or slow
// - 8 kHz timebase loss qualified by active reference
// - each input loss on own status bit
// - monitor off: pin shows requested input loss
// - selection low first input, high second
module rimon_top #(
  parameter int GATE_SHIFT = 0
) (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic       FIRST_REFERENCE_INPUT,
  input  wire logic       SECOND_REFERENCE_INPUT,
  input  wire logic       TIMEBASE_REFERENCE_INPUT,
  input  wire logic [1:0] FIRST_STRAP_PIN,
  input  wire logic       REF_SELECT,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WE,
  input  wire logic       REG_RE,
  output logic      [7:0] REG_RDATA,
  output logic      [2:0] CMOS_PD,
  output logic      [2:0] DIFF_PD,
  output logic      [2:0] XTAL_PD,
  output logic      [2:0] CLOCK_ABSENT_FLAG,
  output logic      [1:0] FREQ_STATUS,
  output logic            FREQ_FAULT,
  output logic            ACTIVE_REF
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [21:0] rimon_gate(input logic tb8k, input logic [1:0] tbsel);
    logic [21:0] g;
    if (tb8k) begin
      g = `RIMON_GATE_8K;
    end else begin
      unique case (tbsel)
        2'h0: g = `RIMON_GATE_10M;
        2'h1: g = `RIMON_GATE_19M;
        2'h2: g = `RIMON_GATE_25M;
        2'h3: g = `RIMON_GATE_38M;
      endcase
    end
    return g;
  endfunction : rimon_gate

  function automatic logic [21:0] rimon_win(input logic nom19, input logic [1:0] sel);
    logic [21:0] w;
    unique case (sel)
      2'h0: w = nom19 ? `RIMON_WIN_19M_0 : `RIMON_WIN_25M_0;
      2'h1: w = nom19 ? `RIMON_WIN_19M_1 : `RIMON_WIN_25M_1;
      2'h2: w = nom19 ? `RIMON_WIN_19M_2 : `RIMON_WIN_25M_2;
      2'h3: w = nom19 ? `RIMON_WIN_19M_3 : `RIMON_WIN_25M_3;
    endcase
    return w;
  endfunction : rimon_win

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] fmt_pair_q;
  logic [7:0] fmt_tb_q;
  logic [7:0] mon_cfg_q;
  logic [1:0] strap_q;
  logic       strap_done_q;
  logic       sel_q;
  logic [2:0] ref_prev_q;
  logic [1:0] stat_q;
  logic [2:0] loss_w;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      fmt_pair_q <= `RIMON_RST_FMT_PAIR;
      fmt_tb_q   <= `RIMON_RST_FMT_TB;
      mon_cfg_q  <= `RIMON_RST_MON_CFG;
    end else if (REG_WE) begin
      case (REG_ADDR)
        `RIMON_ADDR_FMT_PAIR: fmt_pair_q <= REG_WDATA;
        `RIMON_ADDR_FMT_TB:   fmt_tb_q   <= REG_WDATA;
        `RIMON_ADDR_MON_CFG:  mon_cfg_q  <= REG_WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      case (REG_ADDR)
        `RIMON_ADDR_STATUS:   REG_RDATA <= {2'h0, stat_q, sel_q, loss_w};
        `RIMON_ADDR_FMT_PAIR: REG_RDATA <= fmt_pair_q;
        `RIMON_ADDR_FMT_TB:   REG_RDATA <= fmt_tb_q;
        `RIMON_ADDR_MON_CFG:  REG_RDATA <= mon_cfg_q;
        default:              REG_RDATA <= 8'h00;
      endcase
    end
  end

  // strap caught once, on the first edge after reset release
  always_ff @(posedge CLK) begin
    if (SRST) begin
      strap_q      <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q      <= FIRST_STRAP_PIN;
      strap_done_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver modes and power-down
  logic [1:0] fmt_w [3];
  logic [2:0] pd_w;
  logic       use_regs_w;

  always_comb begin
    use_regs_w = fmt_tb_q[`RIMON_USE_REGS_BIT];
    fmt_w[0] = use_regs_w ? fmt_pair_q[`RIMON_FMT0_LSB +: 2] : strap_q;
    fmt_w[1] = use_regs_w ? fmt_pair_q[`RIMON_FMT1_LSB +: 2] : strap_q;
    fmt_w[2] = use_regs_w ? fmt_tb_q[`RIMON_FMT2_LSB +: 2] : strap_q;
    pd_w = {fmt_tb_q[`RIMON_PD2_BIT], fmt_pair_q[`RIMON_PD1_BIT], fmt_pair_q[`RIMON_PD0_BIT]};
  end

  // an unused code (11) leaves all three receivers off
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CMOS_PD <= 3'h7;
      DIFF_PD <= 3'h7;
      XTAL_PD <= 3'h7;
    end else begin
      for (int i = 0; i < 3; i++) begin
        CMOS_PD[i] <= pd_w[i] || (fmt_w[i] != rimon_pkg::FMT_CMOS);
        DIFF_PD[i] <= pd_w[i] || (fmt_w[i] != rimon_pkg::FMT_DIFF);
        XTAL_PD[i] <= pd_w[i] || (fmt_w[i] != rimon_pkg::FMT_XTAL)
                      || ((i < 2) && (sel_q != i[0]));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // selection, edges, presence
  logic [2:0] edge_w;
  logic       act_edge_w;
  logic       tb_edge_w;
  logic       tb8k_w;
  logic       nom19_w;
  logic [12:0] lim_w [3];
  logic [2:0] tick_w;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sel_q      <= 1'b0;
      ref_prev_q <= {TIMEBASE_REFERENCE_INPUT, SECOND_REFERENCE_INPUT, FIRST_REFERENCE_INPUT};
      ACTIVE_REF <= 1'b0;
    end else begin
      sel_q      <= REF_SELECT;
      ACTIVE_REF <= sel_q;
      ref_prev_q <= {TIMEBASE_REFERENCE_INPUT, SECOND_REFERENCE_INPUT, FIRST_REFERENCE_INPUT};
    end
  end

  always_comb begin
    edge_w = {TIMEBASE_REFERENCE_INPUT, SECOND_REFERENCE_INPUT, FIRST_REFERENCE_INPUT}
             & ~ref_prev_q;
    act_edge_w = sel_q ? edge_w[1] : edge_w[0];
    tb_edge_w  = edge_w[2];
    tb8k_w     = mon_cfg_q[`RIMON_TB8K_BIT];
    nom19_w    = mon_cfg_q[`RIMON_NOM_BIT];
    lim_w[0]   = 13'(`RIMON_LOSS_CYC);
    lim_w[1]   = 13'(`RIMON_LOSS_CYC);
    lim_w[2]   = tb8k_w ? (nom19_w ? `RIMON_LIM_8K_19M : `RIMON_LIM_8K_25M)
                        : 13'(`RIMON_LOSS_CYC);
    tick_w     = {tb8k_w ? act_edge_w : 1'b1, 2'h3};
  end

  for (genvar g = 0; g < 3; g++) begin : g_presence
    rimon_presence u_presence (
      .clk       (CLK),
      .srst      (SRST),
      .edge_seen (edge_w[g]),
      .tick      (tick_w[g]),
      .limit     (lim_w[g]),
      .lost      (loss_w[g])
    );
  end

  assign CLOCK_ABSENT_FLAG = loss_w;

  //////////////////////////////////////////////////////////////////////////////
  // frequency monitor
  rimon_pkg::rimon_state_type state_q;
  logic [21:0] act_cnt_q;
  logic [21:0] tb_cnt_q;
  logic        flt_q;
  logic        mon_en_w;
  logic        restart_w;
  logic        gate_end_w;
  logic [21:0] gate_w;
  logic [21:0] nom_w;
  logic [21:0] win_w;
  logic [1:0]  eval_w;

  // gate opens on a timebase edge so no partial period skews the count
  always_comb begin
    mon_en_w   = mon_cfg_q[`RIMON_MON_EN_BIT];
    restart_w  = (REF_SELECT != sel_q) || (REG_WE && (REG_ADDR == `RIMON_ADDR_MON_CFG));
    gate_w     = rimon_gate(tb8k_w, mon_cfg_q[`RIMON_TBSEL_LSB +: 2]) >> GATE_SHIFT;
    nom_w      = (nom19_w ? `RIMON_NOM_19M : `RIMON_NOM_25M) >> GATE_SHIFT;
    win_w      = rimon_win(nom19_w, mon_cfg_q[`RIMON_WIN_LSB +: 2]) >> GATE_SHIFT;
    gate_end_w = tb_edge_w && (tb_cnt_q == gate_w - 22'h00_0001);
    if (flt_q || loss_w[sel_q] || loss_w[2]) begin
      eval_w = rimon_pkg::FS_FAULT;
    end else if (act_cnt_q < nom_w - win_w) begin
      eval_w = rimon_pkg::FS_SLOW;
    end else if (act_cnt_q > nom_w + win_w) begin
      eval_w = rimon_pkg::FS_FAST;
    end else begin
      eval_w = rimon_pkg::FS_VALID;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST || !mon_en_w) begin
      state_q   <= rimon_pkg::ST_IDLE;
      act_cnt_q <= 22'h00_0000;
      tb_cnt_q  <= 22'h00_0000;
      flt_q     <= 1'b0;
      stat_q    <= rimon_pkg::FS_VALID;
    end else begin
      unique case (state_q)
        rimon_pkg::ST_IDLE: begin
          act_cnt_q <= 22'h00_0000;
          tb_cnt_q  <= 22'h00_0000;
          flt_q     <= 1'b0;
          if (loss_w[2]) begin
            stat_q <= rimon_pkg::FS_FAULT;
          end
          if (tb_edge_w && !restart_w) begin
            state_q <= rimon_pkg::ST_MEAS;
          end
        end
        rimon_pkg::ST_MEAS: begin
          if (restart_w) begin
            state_q <= rimon_pkg::ST_IDLE;
          end else if (gate_end_w) begin
            stat_q    <= eval_w;
            act_cnt_q <= 22'h00_0000;
            tb_cnt_q  <= 22'h00_0000;
            flt_q     <= 1'b0;
          end else if (loss_w[2]) begin
            state_q <= rimon_pkg::ST_IDLE;
            stat_q  <= rimon_pkg::FS_FAULT; // no timebase, the gate never closes
          end else begin
            if (act_edge_w && (act_cnt_q != 22'h3F_FFFF)) begin
              act_cnt_q <= act_cnt_q + 22'h00_0001;
            end
            if (tb_edge_w) begin
              tb_cnt_q <= tb_cnt_q + 22'h00_0001;
            end
            flt_q <= flt_q || loss_w[sel_q] || loss_w[2];
          end
        end
        default: state_q <= rimon_pkg::ST_IDLE;
      endcase
    end
  end

  assign FREQ_STATUS = stat_q;

  // disabled monitor hands the pin over to the requested input's loss
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FREQ_FAULT <= 1'b0;
    end else begin
      FREQ_FAULT <= mon_en_w ? |stat_q : loss_w[sel_q];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  fault_pin_a: assert property (@(posedge CLK) disable iff (SRST)
    ##1 $past(mon_en_w) |-> FREQ_FAULT == (|$past(stat_q)))
    else $error("fault pin differs from status OR");
  pin_when_off_a: assert property (@(posedge CLK) disable iff (SRST)
    ##1 !$past(mon_en_w) |-> FREQ_FAULT == $past(loss_w[sel_q]))
    else $error("fault pin does not follow requested loss");
  cmos_pd_a: assert property (@(posedge CLK) disable iff (SRST)
    (pd_w[0] || fmt_w[0] == rimon_pkg::FMT_XTAL) |=> CMOS_PD[0])
    else $error("CMOS receiver left on");
  diff_pd_a: assert property (@(posedge CLK) disable iff (SRST)
    (!pd_w[1] && fmt_w[1] == rimon_pkg::FMT_DIFF) |=> !DIFF_PD[1])
    else $error("differential receiver wrongly off");
  xtal_pd_a: assert property (@(posedge CLK) disable iff (SRST)
    sel_q |=> XTAL_PD[0])
    else $error("unselected crystal receiver on");
  mon_off_a: assert property (@(posedge CLK) disable iff (SRST)
    !mon_en_w |=> stat_q == rimon_pkg::FS_VALID && state_q == rimon_pkg::ST_IDLE)
    else $error("monitor active while disabled");
  slow_eval_a: assert property (@(posedge CLK) disable iff (SRST)
    (mon_en_w && state_q == rimon_pkg::ST_MEAS && gate_end_w && !restart_w && !flt_q
     && !loss_w[sel_q] && !loss_w[2] && act_cnt_q < nom_w - win_w)
    |=> stat_q == rimon_pkg::FS_SLOW)
    else $error("slow reference not reported");
  fault_eval_a: assert property (@(posedge CLK) disable iff (SRST)
    (mon_en_w && state_q == rimon_pkg::ST_MEAS && gate_end_w && !restart_w && flt_q)
    |=> stat_q == rimon_pkg::FS_FAULT)
    else $error("fault during gate not reported");
  tb_limit_a: assert property (@(posedge CLK) disable iff (SRST)
    tb8k_w |-> lim_w[2] == (nom19_w ? 13'h1028 : 13'h1002))
    else $error("wrong 8 kHz loss limit");
  active_sel_a: assert property (@(posedge CLK) disable iff (SRST)
    ##2 ACTIVE_REF == $past(REF_SELECT, 2))
    else $error("active reference does not follow selection");
  valid_c: cover property (@(posedge CLK) disable iff (SRST)
    gate_end_w && state_q == rimon_pkg::ST_MEAS && eval_w == rimon_pkg::FS_VALID);
  fast_c: cover property (@(posedge CLK) disable iff (SRST) stat_q == rimon_pkg::FS_FAST);
  slow_c: cover property (@(posedge CLK) disable iff (SRST) stat_q == rimon_pkg::FS_SLOW);
  fault_off_c: cover property (@(posedge CLK) disable iff (SRST) !mon_en_w && FREQ_FAULT);

endmodule : rimon_top

// >>> tb/rimon_refsrc.sv
//////////////////////////////////////////////////////////////////////////////
module rimon_refsrc (
  input  wire logic [2:0] run,
  input  int              half_ps [3],
  output logic      [2:0] ref_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // a halted source rests low, like a stopped oscillator
  // odd start offsets keep source edges clear of the sampling clock edges
  for (genvar i = 0; i < 3; i++) begin : g_src
    initial begin
      ref_clk[i] = 1'b0;
      #(0.7ns + i * 0.2ns);
      forever begin
        #(half_ps[i] * 1ps);
        ref_clk[i] = run[i] ? ~ref_clk[i] : 1'b0;
      end
    end
  end
endmodule : rimon_refsrc

// >>> tb/reference_input_monitor_tb.sv
//////////////////////////////////////////////////////////////////////////////
module reference_input_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       CLK             = 1'b0;
  logic       SRST            = 1'b1;
  logic [1:0] FIRST_STRAP_PIN = 2'h1;
  logic       REF_SELECT      = 1'b0;
  logic [7:0] REG_ADDR        = 8'h00;
  logic [7:0] REG_WDATA       = 8'h00;
  logic       REG_WE          = 1'b0;
  logic       REG_RE          = 1'b0;
  logic [7:0] REG_RDATA;
  logic [2:0] CMOS_PD, DIFF_PD, XTAL_PD, CLOCK_ABSENT_FLAG;
  logic [1:0] FREQ_STATUS;
  logic       FREQ_FAULT, ACTIVE_REF;
  logic [2:0] run             = 3'h7;
  logic [2:0] ref_clk;
  int         half_ps [3]     = '{25000, 20000, 50000};
  int         fail_count      = 0;
  int         num_checks      = 0;

  always #2 CLK = ~CLK;

  rimon_refsrc src (.run(run), .half_ps(half_ps), .ref_clk(ref_clk));

  rimon_top #(.GATE_SHIFT(8)) dut (
    .CLK                     (CLK),
    .SRST                    (SRST),
    .FIRST_REFERENCE_INPUT   (ref_clk[0]),
    .SECOND_REFERENCE_INPUT  (ref_clk[1]),
    .TIMEBASE_REFERENCE_INPUT(ref_clk[2]),
    .FIRST_STRAP_PIN         (FIRST_STRAP_PIN),
    .REF_SELECT              (REF_SELECT),
    .REG_ADDR                (REG_ADDR),
    .REG_WDATA               (REG_WDATA),
    .REG_WE                  (REG_WE),
    .REG_RE                  (REG_RE),
    .REG_RDATA               (REG_RDATA),
    .CMOS_PD                 (CMOS_PD),
    .DIFF_PD                 (DIFF_PD),
    .XTAL_PD                 (XTAL_PD),
    .CLOCK_ABSENT_FLAG       (CLOCK_ABSENT_FLAG),
    .FREQ_STATUS             (FREQ_STATUS),
    .FREQ_FAULT              (FREQ_FAULT),
    .ACTIVE_REF              (ACTIVE_REF)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : wait_cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WE = 1'b1;
    @(negedge CLK);
    REG_WE = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RE = 1'b1;
    @(negedge CLK);
    REG_RE = 1'b0;
    d = REG_RDATA;
  endtask : rd

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask : chk_reg

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_reg(8'h80, 8'h00);
    chk_reg(8'h81, 8'h00);
    chk_reg(8'h83, 8'h00);
    chk_reg(8'h55, 8'h00);
    wr(8'h21, 8'hFF);
    chk_reg(8'h21, 8'h00);
    check(8'(CMOS_PD), 8'h07);
    check(8'(DIFF_PD), 8'h00);
    check(8'(XTAL_PD), 8'h07);
    check(8'(CLOCK_ABSENT_FLAG), 8'h00);
  endtask : t_reset

  task automatic t_formats();
    logic [1:0] f;
    for (int i = 0; i < 3; i++) begin
      f = 2'(i);
      wr(8'h80, {2'b00, f, 2'b00, f});
      wr(8'h81, {6'h20, f});
      wait_cyc(4);
      check(8'(CMOS_PD), (f != 2'h0) ? 8'h07 : 8'h00);
      check(8'(DIFF_PD), (f != 2'h1) ? 8'h07 : 8'h00);
      check(8'(XTAL_PD), (f != 2'h2) ? 8'h07 : 8'h02);
      chk_reg(8'h80, {2'b00, f, 2'b00, f});
    end
    // second input requested: its crystal receiver and the timebase's stay on, the first's goes off
    REF_SELECT = 1'b1;
    wait_cyc(4);
    check(8'(XTAL_PD), 8'h01);
    REF_SELECT = 1'b0;
    // crystal selected everywhere with every power-down bit set, so all receivers off
    wr(8'h80, 8'h66);
    wr(8'h81, 8'h86);
    wait_cyc(4);
    check(8'(CMOS_PD), 8'h07);
    check(8'(DIFF_PD), 8'h07);
    check(8'(XTAL_PD), 8'h07);
    wr(8'h80, 8'h00);
    wr(8'h81, 8'h80);
    wait_cyc(4);
  endtask : t_formats

  task automatic t_loss();
    run[1] = 1'b0;
    wait_cyc(300);
    check(8'(CLOCK_ABSENT_FLAG), 8'h02);
    chk_reg(8'h21, 8'h02);
    check(8'(FREQ_FAULT), 8'h00);
    REF_SELECT = 1'b1;
    wait_cyc(4);
    check(8'(FREQ_FAULT), 8'h01);
    chk_reg(8'h21, 8'h0A);
    run[1] = 1'b1;
    wait_cyc(40);
    check(8'(CLOCK_ABSENT_FLAG), 8'h00);
    check(8'(FREQ_FAULT), 8'h00);
    REF_SELECT = 1'b0;
    wait_cyc(4);
  endtask : t_loss

  task automatic t_tb_loss();
    int n;
    wr(8'h83, 8'h80);
    run[2] = 1'b0;
    n = 0;
    while (FREQ_STATUS !== 2'h3 && n < 2000) begin
      @(negedge CLK);
      n++;
    end
    wait_cyc(2);
    check(8'(FREQ_STATUS), 8'h03);
    check(8'(FREQ_FAULT), 8'h01);
    chk_reg(8'h21, 8'h34);
    run[2] = 1'b1;
    wr(8'h83, 8'h00);
    wait_cyc(40);
    check(8'(FREQ_STATUS), 8'h00);
    check(8'(FREQ_FAULT), 8'h00);
    // 8 kHz timebase: loss counts active edges, so 300 idle cycles stay clear
    wr(8'h83, 8'h30);
    run[2] = 1'b0;
    wait_cyc(300);
    check(8'(CLOCK_ABSENT_FLAG), 8'h00);
    wr(8'h83, 8'h00);
    wait_cyc(300);
    check(8'(CLOCK_ABSENT_FLAG), 8'h04);
    run[2] = 1'b1;
    wait_cyc(40);
    check(8'(CLOCK_ABSENT_FLAG), 8'h00);
  endtask : t_tb_loss

  // windows shrink to zero counts at this gate shift, so only clear
  // slow and fast offsets give a result that does not hang on edge phase
  task automatic t_measure(input logic [7:0] cfg, input logic sel, input int tb_half,
                           input logic [1:0] exp);
    int n;
    REF_SELECT = sel;
    half_ps[2] = tb_half;
    wait_cyc(40);
    wr(8'h83, cfg);
    n = 0;
    while (FREQ_STATUS === 2'h0 && n < 45000) begin
      @(negedge CLK);
      n++;
    end
    wait_cyc(2);
    check(8'(FREQ_STATUS), 8'(exp));
    check(8'(FREQ_FAULT), 8'h01);
    chk_reg(8'h21, {2'b00, exp, sel, 3'b000});
    check(8'(ACTIVE_REF), 8'(sel));
    wr(8'h83, 8'h00);
    wait_cyc(4);
  endtask : t_measure

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge CLK);
    SRST = 1'b0;
    wait_cyc(40);
    t_reset();
    t_formats();
    t_loss();
    t_tb_loss();
    // first input at 20 MHz checked against 25 MHz on a 10 MHz timebase
    t_measure(8'h83, 1'b0, 50000, 2'h1);
    // second at 25 MHz against 19.44 MHz, 25 MHz timebase; expect fast
    t_measure(8'hA9, 1'b1, 20000, 2'h2);
    report_and_stop();
  end

  // two gates of about 39k cycles each dominate; a clean run ends near 80k
  initial begin
    repeat (95000) @(posedge CLK);
    fail_count++;
    report_and_stop();
  end
endmodule : reference_input_monitor_tb
